// File: rtl/rps_sequencer.sv
// resource power sequencer with register port and power-request pins
// assumes all inputs synchronous to clk_sys; lpo_clk is a slow square
// wave sampled here, its rising edge is one sequencer tick
`timescale 1ns/1ps
`default_nettype none

module rps_sequencer (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire rps_pkg::rps_bus_req_t   bus,
  output logic [31:0]                  rd_data,
  input  wire logic [rps_pkg::NUM_CLK-1:0] core_clk_req,
  input  wire logic                    lpo_clk,
  input  wire logic                    wlan_power_request,
  input  wire logic                    bt_power_request,
  input  wire logic                    shutdown_req,
  output logic [rps_pkg::NUM_RES-1:0]  resource_en,
  output logic                         regulator_en,
  output logic                         wlan_rst_n,
  output logic                         wlan_pd_en,
  output logic                         bt_pd_en,
  output logic                         out_oe_n
);

  ////////////////////////////////////////////////////////////////////////
  // state
  rps_pkg::rps_state_t st_reg;  // every flip-flop of the block
  rps_pkg::rps_state_t st_next; // next value of all of it

  // combinational helpers
  logic                        tick;     // one slow sequencer cycle
  logic [rps_pkg::NUM_RES-1:0] req;      // required resource set
  logic [rps_pkg::NUM_RES-1:0] dep_up;   // some dependent still powered
  logic [rps_pkg::NUM_RES-1:0] deps_ok;  // all dependencies enabled
  logic [rps_pkg::NUM_RES-1:0] settled;  // enabled and not moving
  logic [31:0]                 rd_word;  // decoded read value

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign rd_data      = st_reg.rdata;
  assign resource_en  = st_reg.res_en;
  assign regulator_en = st_reg.reg_en;
  assign wlan_rst_n   = st_reg.wlan_rst_n;
  assign wlan_pd_en   = st_reg.pulldn[rps_pkg::PD_WLAN_BIT];
  assign bt_pd_en     = st_reg.pulldn[rps_pkg::PD_BT_BIT];
  assign out_oe_n     = st_reg.oe_n;

  ////////////////////////////////////////////////////////////////////////
  // required set, dependency checks, read decode
  always_comb begin
    // slow tick from the sampled low-power clock edge
    tick = lpo_clk & ~st_reg.lpo_q;

    // three request sources combined
    req = st_reg.min_mask;
    for (int c = 0; c < rps_pkg::NUM_CLK; c++) begin
      // clock request expands to its resource set
      if (core_clk_req[c]) begin
        req = req | st_reg.clk_map[c];
      end
    end
    for (int t = 0; t < rps_pkg::NUM_RTMR; t++) begin
      // active request timer holds its resources
      if (st_reg.rtmr[t].cnt != 16'h0000) begin
        req = req | st_reg.rtmr[t].mask;
      end
    end
    // pull in dependencies, deep enough for any chain
    for (int k = 0; k < rps_pkg::NUM_RES; k++) begin
      for (int i = 0; i < rps_pkg::NUM_RES; i++) begin
        if (req[i]) begin
          req = req | st_reg.cfg[i].dep;
        end
      end
    end

    // enabled and not in transition
    settled = st_reg.on & ~st_reg.pend;
    for (int i = 0; i < rps_pkg::NUM_RES; i++) begin
      // any dependent powered or on its way
      dep_up[i] = 1'b0;
      for (int j = 0; j < rps_pkg::NUM_RES; j++) begin
        if (st_reg.cfg[j].dep[i] && (st_reg.on[j] || st_reg.pend[j])) begin
          dep_up[i] = 1'b1;
        end
      end
      // every dependency fully enabled
      deps_ok[i] = ((st_reg.cfg[i].dep & ~settled) == 8'h00);
    end

    // read decode, unmapped and misaligned read zero
    rd_word = 32'h0000_0000;
    if (bus.addr[1:0] != 2'h0) begin
      rd_word = 32'h0000_0000;
    end else if (bus.addr == rps_pkg::OFF_MIN) begin
      rd_word[7:0] = st_reg.min_mask;
    end else if (bus.addr == rps_pkg::OFF_STATUS) begin
      rd_word[rps_pkg::STAT_ON_LSB +: 8]   = st_reg.on;
      rd_word[rps_pkg::STAT_PEND_LSB +: 8] = st_reg.pend;
    end else if (bus.addr == rps_pkg::OFF_PULLDN) begin
      rd_word[1:0] = st_reg.pulldn;
    end else if (bus.addr[7:4] == rps_pkg::OFF_CLKMAP[7:4]) begin
      rd_word[7:0] = st_reg.clk_map[bus.addr[3:2]];
    end else if (bus.addr[7:5] == rps_pkg::OFF_RESCFG[7:5]) begin
      rd_word[23:0] = st_reg.cfg[bus.addr[4:2]];
    end else if (bus.addr[7:3] == rps_pkg::OFF_RTMR[7:3]) begin
      rd_word[23:0] = st_reg.rtmr[bus.addr[2]];
    end else if (bus.addr[7:5] == rps_pkg::OFF_TIMER[7:5]) begin
      rd_word[7:0] = st_reg.timer[bus.addr[4:2]];
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.lpo_q = lpo_clk;
    // read data stands only in the cycle after the strobe
    st_next.rdata = bus.re ? rd_word : 32'h0000_0000;

    // per-resource sequencing, once per slow tick
    if (tick) begin
      for (int i = 0; i < rps_pkg::NUM_RES; i++) begin
        if (st_reg.pend[i]) begin
          // counting transition
          st_next.timer[i] = st_reg.timer[i] - 8'h01;
          if (st_reg.timer[i] == 8'h01) begin
            // expiry ends the transition
            st_next.pend[i] = 1'b0;
            st_next.on[i]   = ~st_reg.on[i];
          end
        end else if (st_reg.on[i] && !req[i] && !dep_up[i]) begin
          // unrequested, nothing above it powered
          if (st_reg.cfg[i].t_off == 8'h00) begin
            st_next.on[i] = 1'b0;
          end else begin
            st_next.timer[i] = st_reg.cfg[i].t_off;
            st_next.pend[i]  = 1'b1;
          end
        end else if (!st_reg.on[i] && req[i] && deps_ok[i]) begin
          // requested, everything below it enabled
          if (st_reg.cfg[i].t_on == 8'h00) begin
            st_next.on[i] = 1'b1;
          end else begin
            st_next.timer[i] = st_reg.cfg[i].t_on;
            st_next.pend[i]  = 1'b1;
          end
        end
      end
      // request timers run on the same tick
      for (int t = 0; t < rps_pkg::NUM_RTMR; t++) begin
        if (st_reg.rtmr[t].cnt != 16'h0000) begin
          st_next.rtmr[t].cnt = st_reg.rtmr[t].cnt - 16'h0001;
        end
      end
    end

    // register writes, after the tick so software wins
    if (bus.we && (bus.addr[1:0] == 2'h0)) begin
      if (bus.addr == rps_pkg::OFF_MIN) begin
        st_next.min_mask = bus.wdata[7:0];
      end else if (bus.addr == rps_pkg::OFF_PULLDN) begin
        // software may switch pull-downs off
        st_next.pulldn = bus.wdata[1:0];
      end else if (bus.addr[7:4] == rps_pkg::OFF_CLKMAP[7:4]) begin
        st_next.clk_map[bus.addr[3:2]] = bus.wdata[7:0];
      end else if (bus.addr[7:5] == rps_pkg::OFF_RESCFG[7:5]) begin
        st_next.cfg[bus.addr[4:2]] = rps_pkg::rps_cfg_t'(bus.wdata[23:0]);
      end else if (bus.addr[7:3] == rps_pkg::OFF_RTMR[7:3]) begin
        st_next.rtmr[bus.addr[2]] = rps_pkg::rps_rtmr_t'(bus.wdata[23:0]);
      end
    end

    // drive enables: on when settled on or turning on
    st_next.res_en = st_next.on ^ st_next.pend;
    // regulators follow either request line
    st_next.reg_en = wlan_power_request | bt_power_request;
    // wlan section out of reset only while its request is high
    st_next.wlan_rst_n = wlan_power_request;
    st_next.oe_n = 1'b0;

    // shutdown: drop all state, float outputs, ignore inputs
    if (shutdown_req) begin
      st_next = '0;
      st_next.min_mask = rps_pkg::MIN_RST;
      st_next.pulldn = rps_pkg::PULLDN_RST;
      st_next.oe_n = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // everything off, pull-downs on
      st_reg <= '0;
      st_reg.min_mask <= rps_pkg::MIN_RST;
      st_reg.pulldn <= rps_pkg::PULLDN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

`default_nettype wire

// File: rtl/rps_pkg.sv
// constants, field layouts and carrier types for the resource sequencer
// assumes a single 100 MHz system clock and a plain register port
//
// What this block does
// - request is clocks, minimum mask, timers
// - clock requests map to resource sets
// - each resource in one of four states
// - timer zero when settled, nonzero in transition
// - load timer with on or off delay
// - nonzero timers count down per slow tick
// - timer zero ends transition into final state
// - zero on delay enables immediately
// - zero off delay disables immediately
// - recompute required set every sequencer tick
// - timer expiry clears pending, toggles on bit
// - compare required set against current status
// - disable unrequested resource without powered dependents
// - enable requested resource once dependencies enabled
// - shutdown tristates outputs, ignores most inputs
// - leaving shutdown equals fresh power up
// - wlan request releases wlan reset
// - regulator enable is OR of both requests
// - pull-downs on after reset, software can disable
package rps_pkg;

  ////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_RES  = 8;  // sequenced resources
  localparam int NUM_CLK  = 4;  // core clock request lines
  localparam int NUM_RTMR = 2;  // resource request timers
  localparam int ADDR_W   = 8;  // register port address width

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_MIN    = 8'h00; // minimum_resource_mask
  localparam logic [7:0] OFF_STATUS = 8'h04; // on and pending bits
  localparam logic [7:0] OFF_PULLDN = 8'h08; // pull-down controls
  localparam logic [7:0] OFF_CLKMAP = 8'h10; // clock map, 4 words
  localparam logic [7:0] OFF_RTMR   = 8'h40; // request timers, 2 words
  localparam logic [7:0] OFF_RESCFG = 8'h20; // resource config, 8 words
  localparam logic [7:0] OFF_TIMER  = 8'h60; // timer readback, 8 words

  ////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int STAT_ON_LSB   = 0;  // resource_on_bit field
  localparam int STAT_PEND_LSB = 8;  // transition_pending_bit field
  localparam int PD_WLAN_BIT   = 0;  // wlan pull-down enable
  localparam int PD_BT_BIT     = 1;  // bt pull-down enable
  localparam logic [1:0] PULLDN_RST = 2'h3; // both pull-downs on
  localparam logic [7:0] MIN_RST    = 8'h00; // nothing forced on

  ////////////////////////////////////////////////////////////////////////
  // carrier types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;  // byte address
    logic [31:0]       wdata; // write data
    logic              we;    // write strobe
    logic              re;    // read strobe
  } rps_bus_req_t;

  // per-resource config word: [23:16] deps, [15:8] off, [7:0] on
  typedef struct packed {
    logic [7:0] dep;   // resources this one needs enabled
    logic [7:0] t_off; // turn-off delay in slow ticks
    logic [7:0] t_on;  // turn-on delay in slow ticks
  } rps_cfg_t;

  // request timer word: [23:8] count, [7:0] resource mask
  typedef struct packed {
    logic [15:0] cnt;  // slow ticks left, active while nonzero
    logic [7:0]  mask; // resources held on while active
  } rps_rtmr_t;

  // whole state of the sequencer
  typedef struct packed {
    logic [7:0]                min_mask;
    logic [NUM_CLK-1:0][7:0]   clk_map;
    rps_cfg_t [NUM_RES-1:0]    cfg;
    rps_rtmr_t [NUM_RTMR-1:0]  rtmr;
    logic [NUM_RES-1:0]        on;
    logic [NUM_RES-1:0]        pend;
    logic [NUM_RES-1:0][7:0]   timer;
    logic [1:0]                pulldn;
    logic                      lpo_q;
    logic [31:0]               rdata;
    logic [NUM_RES-1:0]        res_en;
    logic                      reg_en;
    logic                      wlan_rst_n;
    logic                      oe_n;
  } rps_state_t;

endpackage

// File: verification/rps_props.sv
// port checker for the resource sequencer
// assumes it is bound onto rps_sequencer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rps_props (
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  input wire rps_pkg::rps_bus_req_t       bus,
  input wire logic [31:0]                 rd_data,
  input wire logic                        lpo_clk,
  input wire logic                        wlan_power_request,
  input wire logic                        bt_power_request,
  input wire logic                        shutdown_req,
  input wire logic [rps_pkg::NUM_RES-1:0] resource_en,
  input wire logic                        regulator_en,
  input wire logic                        wlan_rst_n,
  input wire logic                        wlan_pd_en,
  input wire logic                        bt_pd_en,
  input wire logic                        out_oe_n
);
  logic [3:0] dly_reg; // lpo, tick, shutdown, pull-down write
  logic       tick;    // slow clock rising edge seen
  logic       wr_pd;   // pull-down register written
  assign tick  = lpo_clk & ~dly_reg[3];
  assign wr_pd = bus.we && bus.addr == rps_pkg::OFF_PULLDN;
  // delayed copies, tolerate one cycle of output lag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dly_reg <= 4'h0;
    end else begin
      dly_reg <= {lpo_clk, tick, shutdown_req, wr_pd};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  property p_reg_or;
    !shutdown_req
      |=> regulator_en == $past(wlan_power_request | bt_power_request);
  endproperty
  a_reg_or: assert property (p_reg_or)
    else $error("regulator enable wrong");
  property p_wlan_rst;
    !shutdown_req |=> wlan_rst_n == $past(wlan_power_request);
  endproperty
  a_wlan_rst: assert property (p_wlan_rst)
    else $error("wlan reset wrong");
  property p_rst_gate;
    wlan_rst_n |-> regulator_en;
  endproperty
  a_rst_gate: assert property (p_rst_gate)
    else $error("wlan out of reset unpowered");
  property p_shut;
    shutdown_req [*2]
      |=> out_oe_n && !regulator_en && !wlan_rst_n && resource_en == '0;
  endproperty
  a_shut: assert property (p_shut)
    else $error("outputs live in shutdown");
  property p_leave;
    $fell(shutdown_req) |-> resource_en == '0 && wlan_pd_en && bt_pd_en;
  endproperty
  a_leave: assert property (p_leave)
    else $error("state kept over shutdown");
  property p_en_tick;
    !tick && !dly_reg[2] && !shutdown_req && !dly_reg[1]
      |=> $stable(resource_en);
  endproperty
  a_en_tick: assert property (p_en_tick)
    else $error("enable moved without tick");
  property p_pd;
    !wr_pd && !dly_reg[0] && !shutdown_req && !dly_reg[1]
      |=> $stable({wlan_pd_en, bt_pd_en});
  endproperty
  a_pd: assert property (p_pd)
    else $error("pull-down moved unasked");
  property p_rd;
    !bus.re |=> rd_data == 32'h0;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read data outside read");
  c_tick: cover property (tick && resource_en != '0);
  c_shut: cover property (shutdown_req [*2]);
  c_pd: cover property (wr_pd);
endmodule
bind rps_sequencer rps_props u_rps_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .bus(bus), .rd_data(rd_data), .lpo_clk(lpo_clk),
  .wlan_power_request(wlan_power_request),
  .bt_power_request(bt_power_request), .shutdown_req(shutdown_req),
  .resource_en(resource_en), .regulator_en(regulator_en),
  .wlan_rst_n(wlan_rst_n), .wlan_pd_en(wlan_pd_en), .bt_pd_en(bt_pd_en),
  .out_oe_n(out_oe_n));
`default_nettype wire

// File: verification/rps_host_model.sv
// host model driving the two power-request pins
// assumes a released pin drifts unless its pull-down is on
`timescale 1ns/1ps
`default_nettype none
module rps_host_model (
  input  wire logic       clk_sys,
  input  wire logic [1:0] drive,    // 1 = host drives, bit0 wlan
  input  wire logic [1:0] level,    // driven level
  input  wire logic       wlan_pd_en,
  input  wire logic       bt_pd_en,
  output logic            wlan_power_request,
  output logic            bt_power_request
);
  logic [1:0] last_reg = 2'h0; // last driven level
  logic [1:0] pd;              // pull-downs per pin
  assign pd = {bt_pd_en, wlan_pd_en};
  // remember what the host last put on each pin
  always_ff @(posedge clk_sys) begin
    last_reg <= (drive & level) | (~drive & last_reg);
  end
  // host level, else pull-down, else drift away from last level
  assign wlan_power_request = drive[0] ? level[0]
                                       : ~pd[0] & ~last_reg[0];
  assign bt_power_request   = drive[1] ? level[1]
                                       : ~pd[1] & ~last_reg[1];
endmodule
`default_nettype wire

// File: verification/rps_sequencer_test.sv
// self-checking bench for the resource sequencer
// assumes rps_pkg, rps_sequencer, checker and host model compiled first
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer_test;
  logic                         clk_sys, rst_n, lpo_clk, shutdown_req;
  rps_pkg::rps_bus_req_t        bus;
  logic [31:0]                  rd_data;
  logic [rps_pkg::NUM_CLK-1:0]  core_clk_req;
  logic [rps_pkg::NUM_RES-1:0]  resource_en;
  logic [1:0]                   drive, level;
  logic                         wl_req, bt_req, regulator_en, wlan_rst_n;
  logic                         wlan_pd_en, bt_pd_en, out_oe_n;
  int                           n_errors, compares;
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  rps_sequencer u_rps_sequencer (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus(bus), .rd_data(rd_data), .core_clk_req(core_clk_req),
    .lpo_clk(lpo_clk), .wlan_power_request(wl_req),
    .bt_power_request(bt_req), .shutdown_req(shutdown_req),
    .resource_en(resource_en), .regulator_en(regulator_en),
    .wlan_rst_n(wlan_rst_n), .wlan_pd_en(wlan_pd_en),
    .bt_pd_en(bt_pd_en), .out_oe_n(out_oe_n));
  rps_host_model u_rps_host_model (.clk_sys(clk_sys), .drive(drive),
    .level(level), .wlan_pd_en(wlan_pd_en), .bt_pd_en(bt_pd_en),
    .wlan_power_request(wl_req), .bt_power_request(bt_req));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.we    <= 1'b1;
    @(posedge clk_sys);
    bus.we <= 1'b0;
    // one idle edge, so a following write never re-raises we here
    @(posedge clk_sys);
  endtask
  // read one word and compare it
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus.addr <= a;
    bus.re   <= 1'b1;
    @(posedge clk_sys);
    bus.re <= 1'b0;
    @(negedge clk_sys);
    chk(rd_data, e);
    @(posedge clk_sys);
  endtask
  task automatic tick;
    lpo_clk <= 1'b1;
    repeat (2) @(posedge clk_sys);
    lpo_clk <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic close_out;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(32'({wlan_pd_en, bt_pd_en, out_oe_n}), 32'h6);
    rchk(rps_pkg::OFF_MIN, 32'h0);
    rchk(rps_pkg::OFF_PULLDN, 32'h3);
    rchk(8'h80, 32'h0);
    wr(rps_pkg::OFF_STATUS, 32'hffff);
    rchk(rps_pkg::OFF_STATUS, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_pins;
    for (int i = 0; i < 4; i++) begin
      level <= i[1:0];
      repeat (2) @(posedge clk_sys);
      chk(32'({regulator_en, wlan_rst_n}), 32'({|i[1:0], i[0]}));
    end
    level <= 2'h0;
    @(posedge clk_sys);
    drive <= 2'h0;
    repeat (2) @(posedge clk_sys);
    chk(32'(regulator_en), 32'h0);
    wr(rps_pkg::OFF_PULLDN, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(32'({regulator_en, wlan_rst_n, wlan_pd_en, bt_pd_en}), 32'hc);
    wr(rps_pkg::OFF_PULLDN, 32'h3);
    drive <= 2'h3;
    $display("pin test done");
  endtask
  // res0 slow both ways, res1 instant and depends on res0
  task automatic t_seq;
    logic [15:0] st [9] = '{16'h0100, 16'h0100, 16'h0100, 16'h0001,
      16'h0003, 16'h0001, 16'h0101, 16'h0101, 16'h0000};
    wr(8'h20, 32'h000203);
    wr(8'h24, 32'h010000);
    wr(rps_pkg::OFF_MIN, 32'h3);
    for (int k = 0; k < 9; k++) begin
      if (k == 5) begin
        wr(rps_pkg::OFF_MIN, 32'h0);
      end
      tick();
      rchk(rps_pkg::OFF_STATUS, 32'(st[k]));
      if (k < 3 || k == 6) begin
        rchk(8'h60, 32'(k < 3 ? 3 - k : 2));
      end
    end
    rchk(8'h60, 32'h0);
    $display("sequence test done");
  endtask
  task automatic t_req;
    wr(8'h14, 32'h04);
    core_clk_req <= 4'h2;
    tick();
    rchk(rps_pkg::OFF_STATUS, 32'h4);
    core_clk_req <= 4'h0;
    tick();
    rchk(rps_pkg::OFF_STATUS, 32'h0);
    wr(rps_pkg::OFF_RTMR, 32'h000208);
    for (int k = 0; k < 3; k++) begin
      tick();
      rchk(rps_pkg::OFF_STATUS, 32'(k < 2 ? 8 : 0));
    end
    $display("request test done");
  endtask
  task automatic t_shut;
    level <= 2'h3;
    wr(rps_pkg::OFF_MIN, 32'h04);
    tick();
    chk(32'(resource_en), 32'h4);
    shutdown_req <= 1'b1;
    wr(rps_pkg::OFF_MIN, 32'h01);
    repeat (2) @(posedge clk_sys);
    chk(32'({out_oe_n, regulator_en, resource_en}), 32'h200);
    shutdown_req <= 1'b0;
    @(posedge clk_sys);
    rchk(rps_pkg::OFF_MIN, 32'h0);
    rchk(8'h24, 32'h0);
    chk(32'(regulator_en), 32'h1);
    $display("shutdown test done");
  endtask
  initial begin
    rst_n = 1'b0;
    lpo_clk = 1'b0;
    shutdown_req = 1'b0;
    core_clk_req = '0;
    bus = '0;
    drive = 2'h3;
    level = 2'h0;
    n_errors = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_pins();
    t_seq();
    t_req();
    t_shut();
    close_out();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
